// ### src/tenbaset_params.svh
// Constants for the 10 Mb/s twisted-pair transceiver logic
// Operation
// - Full duplex: no collision from overlap
// - Squelch: cross, opposite, original within windows
// - Data present until crossing gap exceeds 150ns
// - Qualified data: valid flag, reset, lower thresholds
// - Half duplex overlap raises collision immediately
// - Jabber also raises collision
// - Heartbeat pulse after each transmitted frame
// - Heartbeat off in full duplex or disabled
// - Half duplex carrier on transmit and receive
// - Full duplex carrier only on receive
// - Idle link pulse every 16 ms
// - No link pulses disables transmit, receive, overlap collision
// - Override bit forces link good
// - Jabber cutoff after 85 ms transmit
// - Unjab after enable low 500 ms
// - Three inverted pulses latch polarity, invert data
// - Encode nibbles while transmit enable high
// - Frame ends with positive transition
// - Carrier drops soon after last transition
// - Receive clock runs five bits after carrier
`ifndef TENBASET_PARAMS_SVH
`define TENBASET_PARAMS_SVH

// ===========================================================
// Register map
`define TBT_REG_INDEX 8'h1a
`define TBT_BYTE_ADDR (`TBT_REG_INDEX * 4)
`define TBT_RESET_CTRL 3'h0
`define TBT_BIT_SQE_DIS 0
`define TBT_BIT_LINK_OVR 1
`define TBT_BIT_FDX 2
`define TBT_BIT_BAD_POL 8
`define TBT_BIT_JABBER 9
`define TBT_BIT_LINK_OK 10

// ===========================================================
// Timing, in ns or ms, and derived cycle counts
`define TBT_CLK_NS 100
`define TBT_BIT_NS 100
`define TBT_HALF_CELL_NS 100
`define TBT_SQ_WIN_NS 150
`define TBT_SQ_WIN_CYC (`TBT_SQ_WIN_NS / `TBT_CLK_NS)
`define TBT_EOP_GAP_CYC (`TBT_SQ_WIN_NS / `TBT_CLK_NS)
`define TBT_HB_DELAY_NS 1000
`define TBT_HB_DELAY_CYC (`TBT_HB_DELAY_NS / `TBT_CLK_NS)
`define TBT_HB_WIDTH_CYC ((10 * `TBT_BIT_NS) / `TBT_CLK_NS)
`define TBT_RX_POST_CYC ((5 * 2 * `TBT_HALF_CELL_NS) / `TBT_CLK_NS)
`define TBT_LP_PERIOD_MS 16
`define TBT_LP_PERIOD_CYC ((`TBT_LP_PERIOD_MS * 1000000) / `TBT_CLK_NS)
`define TBT_JABBER_MS 85
`define TBT_JABBER_CYC ((`TBT_JABBER_MS * 1000000) / `TBT_CLK_NS)
`define TBT_UNJAB_MS 500
`define TBT_UNJAB_CYC ((`TBT_UNJAB_MS * 1000000) / `TBT_CLK_NS)
`define TBT_LINK_LOSS_MS 100
`define TBT_LINK_LOSS_CYC ((`TBT_LINK_LOSS_MS * 1000000) / `TBT_CLK_NS)
`define TBT_POL_COUNT 3

`endif

// ### src/tenbaset_pkg.sv
// Types shared by the 10 Mb/s twisted-pair transceiver logic
package tenbaset_pkg;

	// Receive squelch sequencer
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_FIRST = 2'b01,
		SQ_SECOND = 2'b10,
		SQ_DATA = 2'b11
	} squelch_state_t;

	// Transmit encoder
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_DATA = 2'b01,
		TX_TAIL = 2'b10
	} tx_state_t;

endpackage

// ### src/tenbaset_transceiver_logic.sv
// 10 Mb/s twisted-pair transceiver control with AHB-Lite register slave
`include "tenbaset_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tenbaset_transceiver_logic #(
	parameter logic [22:0] LP_PERIOD_CYC = 23'(`TBT_LP_PERIOD_CYC),
	parameter logic [22:0] JABBER_CYC = 23'(`TBT_JABBER_CYC),
	parameter logic [22:0] UNJAB_CYC = 23'(`TBT_UNJAB_CYC),
	parameter logic [22:0] LINK_LOSS_CYC = 23'(`TBT_LINK_LOSS_CYC)
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// MII transmit side
	input wire logic tx_clk,
	input wire logic tx_en,
	input wire logic [3:0] txd,
	// MII receive side
	output logic rx_clk,
	output logic rx_dv,
	output logic [3:0] rxd,
	output logic crs,
	output logic col,
	// Twisted-pair line
	output logic tp_tx_out,
	output logic tp_tx_oe,
	input wire logic rx_above_pos,
	input wire logic rx_above_neg,
	output logic squelch_reduced
);
	import tenbaset_pkg::*;

	// ===========================================================
	// Input synchronisers
	logic [7:0] in_meta;
	logic [7:0] in_sync;
	logic tclk_d;
	wire s_tx_clk = in_sync[7];
	wire s_tx_en = in_sync[6];
	wire [3:0] s_txd = in_sync[5:2];
	wire tclk_rise = s_tx_clk & ~tclk_d;

	// Two stages; only the second stage feeds logic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_meta <= 8'h00;
			in_sync <= 8'h00;
			tclk_d <= 1'b0;
		end else begin
			in_meta <= {tx_clk, tx_en, txd, rx_above_pos, rx_above_neg};
			in_sync <= in_meta;
			tclk_d <= s_tx_clk;
		end
	end

	// ===========================================================
	// Register bus
	logic [2:0] ctrl;
	logic bad_pol;
	logic jabber;
	logic link_good;
	logic dp_write;
	logic dp_hit;
	wire addr_ok = hsel & htrans[1] & hready;
	wire addr_hit = (haddr == 32'(`TBT_BYTE_ADDR));
	wire wr_now = dp_write & dp_hit;
	wire [2:0] ctrl_now = wr_now ? hwdata[2:0] : ctrl;
	wire sqe_pulse_disable = ctrl[`TBT_BIT_SQE_DIS];
	wire link_override = ctrl[`TBT_BIT_LINK_OVR];
	wire fdx = ctrl[`TBT_BIT_FDX];
	wire link_ok = link_override | link_good;
	wire pol_clear = wr_now & hwdata[`TBT_BIT_BAD_POL];
	wire [15:0] status_word = {5'h00, link_ok, jabber, bad_pol,
		5'h00, ctrl_now};

	// Address phase capture; zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_hit <= 1'b0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			dp_write <= addr_ok & hwrite;
			dp_hit <= addr_ok & addr_hit;
			if (addr_ok & ~hwrite) begin
				hrdata <= addr_hit ? {16'h0000, status_word} : 32'h0000_0000;
			end
		end
	end

	// Control bits written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `TBT_RESET_CTRL;
		end else begin
			ctrl <= ctrl_now;
		end
	end

	// ===========================================================
	// Receive squelch and link pulse detection
	squelch_state_t sq_state;
	logic first_pos;
	logic [1:0] sq_win;
	logic [1:0] gap_cnt;
	logic [1:0] inv_run;
	logic [22:0] loss_cnt;
	// Polarity correction swaps the comparators before anything looks
	wire lvl_p = bad_pol ? in_sync[0] : in_sync[1];
	wire lvl_n = bad_pol ? in_sync[1] : in_sync[0];
	wire lvl_orig = first_pos ? lvl_p : lvl_n;
	wire lvl_opp = first_pos ? lvl_n : lvl_p;
	wire win_over = (sq_win >= 2'(`TBT_SQ_WIN_CYC));
	// An isolated crossing with no answer is a link pulse, not data
	wire pulse_seen = (sq_state == SQ_FIRST) & ~lvl_opp & win_over;
	wire pulse_norm = pulse_seen & first_pos;
	wire pulse_inv = pulse_seen & ~first_pos;
	wire rx_act = (sq_state == SQ_DATA) & link_ok;

	// Squelch sequencer; it stays in data until a crossing gap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sq_state <= SQ_IDLE;
			first_pos <= 1'b0;
			sq_win <= 2'h0;
			gap_cnt <= 2'h0;
		end else begin
			case (sq_state)
				SQ_IDLE: begin
					sq_win <= 2'h0;
					gap_cnt <= 2'h0;
					if (lvl_p | lvl_n) begin
						first_pos <= lvl_p;
						sq_state <= SQ_FIRST;
					end
				end
				SQ_FIRST: begin
					sq_win <= sq_win + 2'h1;
					if (lvl_opp) begin
						sq_win <= 2'h0;
						sq_state <= SQ_SECOND;
					end else if (win_over) begin
						sq_state <= SQ_IDLE;
					end
				end
				SQ_SECOND: begin
					sq_win <= sq_win + 2'h1;
					if (lvl_orig) begin
						sq_state <= SQ_DATA;
					end else if (win_over) begin
						sq_state <= SQ_IDLE;
					end
				end
				SQ_DATA: begin
					if (lvl_p | lvl_n) begin
						gap_cnt <= 2'h0;
					end else if (gap_cnt > 2'(`TBT_EOP_GAP_CYC)) begin
						sq_state <= SQ_IDLE;
					end else begin
						gap_cnt <= gap_cnt + 2'h1;
					end
				end
				default: sq_state <= SQ_IDLE;
			endcase
		end
	end

	// Link integrity and polarity; a new detection beats a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_good <= 1'b0;
			loss_cnt <= 23'h0;
			inv_run <= 2'h0;
			bad_pol <= 1'b0;
		end else begin
			if (pulse_seen | (sq_state == SQ_DATA)) begin
				loss_cnt <= 23'h0;
				link_good <= 1'b1;
			end else if (loss_cnt >= LINK_LOSS_CYC) begin
				link_good <= 1'b0;
			end else begin
				loss_cnt <= loss_cnt + 23'h1;
			end
			if (pulse_norm) begin
				inv_run <= 2'h0;
			end else if (pulse_inv) begin
				inv_run <= (inv_run == 2'(`TBT_POL_COUNT)) ? inv_run
					: inv_run + 2'h1;
			end
			if (pulse_inv & (inv_run == 2'(`TBT_POL_COUNT - 1))) begin
				bad_pol <= 1'b1;
			end else if (pol_clear) begin
				bad_pol <= 1'b0;
			end
		end
	end

	// ===========================================================
	// Receive decode towards the MAC
	logic [2:0] nib_phase;
	logic [3:0] rx_shift;
	logic [3:0] post_cnt;
	wire rx_run = rx_act | (post_cnt != 4'h0);

	// Second half of each cell carries the bit value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nib_phase <= 3'h0;
			rx_shift <= 4'h0;
			post_cnt <= 4'h0;
			rxd <= 4'h0;
			rx_dv <= 1'b0;
			rx_clk <= 1'b0;
			squelch_reduced <= 1'b0;
		end else begin
			squelch_reduced <= (sq_state == SQ_DATA);
			if (rx_act) begin
				post_cnt <= 4'(`TBT_RX_POST_CYC);
			end else if (post_cnt != 4'h0) begin
				post_cnt <= post_cnt - 4'h1;
			end
			nib_phase <= rx_run ? nib_phase + 3'h1 : 3'h0;
			rx_clk <= rx_run & nib_phase[2];
			if (rx_act & nib_phase[0]) begin
				rx_shift <= {lvl_p, rx_shift[3:1]};
			end
			if (~rx_act) begin
				rx_dv <= 1'b0;
			end else if (nib_phase == 3'h7) begin
				rxd <= {lvl_p, rx_shift[3:1]};
				rx_dv <= 1'b1;
			end
		end
	end

	// ===========================================================
	// Jabber watchdog
	logic [22:0] jab_cnt;

	// Cut off after long transmit, release after long quiet
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			jab_cnt <= 23'h0;
			jabber <= 1'b0;
		end else if (!jabber) begin
			if (!s_tx_en) begin
				jab_cnt <= 23'h0;
			end else if (jab_cnt >= JABBER_CYC - 23'h1) begin
				jab_cnt <= 23'h0;
				jabber <= 1'b1;
			end else begin
				jab_cnt <= jab_cnt + 23'h1;
			end
		end else begin
			if (s_tx_en) begin
				jab_cnt <= 23'h0;
			end else if (jab_cnt >= UNJAB_CYC - 23'h1) begin
				jab_cnt <= 23'h0;
				jabber <= 1'b0;
			end else begin
				jab_cnt <= jab_cnt + 23'h1;
			end
		end
	end

	// ===========================================================
	// Manchester transmit and link pulses
	tx_state_t tx_state;
	logic [3:0] tx_shift;
	logic [2:0] half_idx;
	logic half_busy;
	logic [22:0] lp_cnt;
	wire tx_allowed = link_ok & ~jabber;
	wire tx_act = s_tx_en & link_ok;
	wire cur_bit = tx_shift[half_idx[2:1]];
	wire frame_end = (tx_state == TX_DATA) & tclk_rise & ~s_tx_en;

	// Each sampled TX clock rise loads a nibble, sent LSB first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state <= TX_IDLE;
			tx_shift <= 4'h0;
			half_idx <= 3'h0;
			half_busy <= 1'b0;
			lp_cnt <= 23'h0;
			tp_tx_out <= 1'b0;
			tp_tx_oe <= 1'b0;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					half_busy <= 1'b0;
					lp_cnt <= (lp_cnt >= LP_PERIOD_CYC - 23'h1) ? 23'h0
						: lp_cnt + 23'h1;
					tp_tx_out <= (lp_cnt == LP_PERIOD_CYC - 23'h1);
					tp_tx_oe <= (lp_cnt == LP_PERIOD_CYC - 23'h1);
					if (tclk_rise & s_tx_en & tx_allowed) begin
						tx_shift <= s_txd;
						half_idx <= 3'h0;
						half_busy <= 1'b1;
						tx_state <= TX_DATA;
					end
				end
				TX_DATA: begin
					lp_cnt <= 23'h0;
					if (!tx_allowed) begin
						// A cut frame still leaves the line from a high level
						tp_tx_out <= 1'b1;
						tp_tx_oe <= 1'b1;
						tx_state <= TX_TAIL;
					end else if (frame_end) begin
						tp_tx_out <= 1'b1;
						tp_tx_oe <= 1'b1;
						tx_state <= TX_TAIL;
					end else begin
						if (tclk_rise) begin
							tx_shift <= s_txd;
							half_idx <= 3'h0;
							half_busy <= 1'b1;
						end else if (half_idx == 3'h7) begin
							half_busy <= 1'b0;
						end else if (half_busy) begin
							half_idx <= half_idx + 3'h1;
						end
						tp_tx_out <= half_idx[0] ? cur_bit : ~cur_bit;
						tp_tx_oe <= 1'b1;
					end
				end
				TX_TAIL: begin
					tp_tx_out <= 1'b0;
					tp_tx_oe <= 1'b0;
					tx_state <= TX_IDLE;
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// ===========================================================
	// Heartbeat, collision and carrier sense
	logic [4:0] hb_cnt;
	wire hb_start = frame_end & ~fdx & ~sqe_pulse_disable;
	wire sqe_on = (hb_cnt != 5'h0) & (hb_cnt <= 5'(`TBT_HB_WIDTH_CYC));
	// Overlap only counts in half duplex with the link up
	wire overlap = ~fdx & tx_act & rx_act;

	// Delay then pulse; a new frame end restarts it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hb_cnt <= 5'h0;
			col <= 1'b0;
			crs <= 1'b0;
		end else begin
			if (hb_start) begin
				hb_cnt <= 5'(`TBT_HB_DELAY_CYC + `TBT_HB_WIDTH_CYC);
			end else if (hb_cnt != 5'h0) begin
				hb_cnt <= hb_cnt - 5'h1;
			end
			col <= overlap | jabber | sqe_on;
			crs <= rx_act | (~fdx & tx_act);
		end
	end

endmodule

`default_nettype wire

// ### testbench/mac_tx_model.sv
// Model of the MAC transmit side of the nibble interface
`timescale 1ns/1ps
`default_nettype none
module mac_tx_model (
	// Nibble transmit interface
	output var logic tx_clk,
	output var logic tx_en,
	output var logic [3:0] txd
);
	// Clock parks low between frames; released data shows a changed value
	initial begin
		tx_clk = 1'b0;
		tx_en = 1'b0;
		txd = 4'ha;
	end
	// Data moves on the falling clock so it is steady at each rise
	// Start a quarter period off the system clock edge to avoid races
	task automatic send(input int n, input logic [3:0] first);
		#25;
		for (int i = 0; i < n; i++) begin
			tx_en = 1'b1;
			txd = first + 4'(i);
			#400 tx_clk = 1'b1;
			#400 tx_clk = 1'b0;
		end
		tx_en = 1'b0;
		txd = ~txd;
		#400 tx_clk = 1'b1;
		#400 tx_clk = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### testbench/tenbaset_transceiver_logic_assertions.sv
// Port checker for the transceiver control logic
`timescale 1ns/1ps
`default_nettype none
module tenbaset_checker #(
	parameter logic [22:0] JABBER_CYC = 23'd300
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	// Transceiver
	input wire logic tx_en,
	input wire logic crs,
	input wire logic col,
	input wire logic tp_tx_out,
	input wire logic tp_tx_oe,
	input wire logic rx_above_pos,
	input wire logic rx_above_neg
);
	logic wr_pend, short_fr;
	logic [2:0] ctrl;
	logic [23:0] tx_run, idle, rx_gap, rx_run;
	wire hit = hsel & htrans[1] & hready & hwrite & (haddr == 32'h68);
	wire rx_act = rx_above_pos | rx_above_neg;
	wire fdx = ctrl[2];
	wire quiet = ctrl[2] | ctrl[0];
	wire [23:0] jab = {1'b0, JABBER_CYC};
	// Shadow of the control bits, plus activity counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			ctrl <= 3'h0;
			tx_run <= 24'h0;
			idle <= 24'h0;
			rx_gap <= 24'hffff;
			rx_run <= 24'h0;
			short_fr <= 1'b1;
		end else begin
			wr_pend <= hit;
			if (wr_pend)
				ctrl <= hwdata[2:0];
			tx_run <= tx_en ? tx_run + 24'h1 : 24'h0;
			idle <= tx_en ? 24'h0 : idle + 24'h1;
			rx_gap <= rx_act ? 24'h0 : rx_gap + 24'h1;
			rx_run <= (rx_gap < 24'h3) ? rx_run + 24'h1 : 24'h0;
			short_fr <= tx_en ? (tx_run < jab) : short_fr;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ===========================================================
	// Assertions
	a_fdx_no_col: assert property (fdx && tx_en && tx_run < jab |-> !col)
		else $error("collision in full duplex");
	a_fdx_crs_rx: assert property (fdx && rx_gap > 24'd12 |-> !crs)
		else $error("carrier without receive in full duplex");
	a_hdx_crs_tx: assert property (!fdx && ctrl[1] && tx_run > 24'd12
		&& tx_run < jab |-> crs) else $error("no carrier on transmit");
	a_hdx_overlap: assert property (!fdx && ctrl[1] && tx_run > 24'd12
		&& tx_run < jab && rx_run > 24'd8 |-> col)
		else $error("overlap without collision");
	a_jabber_col: assert property (ctrl[1] && tx_run > jab + 24'd8 |-> col)
		else $error("jabber without collision");
	a_sqe_pulse: assert property (!quiet && ctrl[1] && short_fr
		&& $fell(tx_en) |-> ##[10:40] col) else $error("heartbeat missing");
	a_sqe_muted: assert property (quiet && short_fr && !tx_en
		&& rx_gap > 24'd12 |-> !col) else $error("heartbeat not muted");
	a_last_rise: assert property ($fell(tp_tx_oe) |-> $past(tp_tx_out))
		else $error("line released from low level");
	a_link_pulse: assert property (tp_tx_oe && idle > 24'd40
		|-> tp_tx_out ##1 !tp_tx_oe) else $error("link pulse shape");
	c_col: cover property ($rose(col));
	c_fdx_tx: cover property (fdx && tx_en);
	c_crs: cover property ($rose(crs));
endmodule
bind tenbaset_transceiver_logic tenbaset_checker #(.JABBER_CYC(JABBER_CYC)) chk (.*);
`default_nettype wire

// ### testbench/tenbaset_transceiver_logic_tb.sv
// Self-checking bench for the transceiver control logic
`timescale 1ns/1ps
`default_nettype none
module tenbaset_transceiver_logic_tb;
	import tenbaset_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic tx_clk, tx_en, rx_clk, rx_dv, crs, col, squelch_reduced;
	logic tp_tx_out, tp_tx_oe, rx_above_pos, rx_above_neg;
	logic [3:0] txd, rxd;
	logic [7:0] bits;
	int fails, tests_run, cyc, n;
	assign hready = hreadyout;
	mac_tx_model mac (.*);
	// Short counts keep the run brief
	tenbaset_transceiver_logic #(.LP_PERIOD_CYC(23'd200),
		.JABBER_CYC(23'd300), .UNJAB_CYC(23'd400),
		.LINK_LOSS_CYC(23'd1000)) dut (.*);
	// ===========================================================
	// Clock and watchdog
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			results();
		end
	end
	// ===========================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// One single transfer; waits on ready in both phases
	task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		ahb(a, 1'b0, 32'h0);
		check("register", exp, r);
	endtask
	task automatic wr(input logic [31:0] d);
		ahb(32'h68, 1'b1, d);
	endtask
	// Alternating comparator levels, one per cycle, then idle
	task automatic burst(input int k, input logic inv);
		for (int i = 0; i < k; i++) begin
			@(posedge hclk);
			rx_above_pos <= ~(i[0] ^ inv);
			rx_above_neg <= i[0] ^ inv;
		end
		@(posedge hclk);
		rx_above_pos <= 1'b0;
		rx_above_neg <= 1'b0;
	endtask
	task automatic count_col(output int c);
		c = 0;
		repeat (60) @(negedge hclk) if (col === 1'b1) c++;
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ===========================================================
	// Main sequence
	initial begin
		{cyc, fails, tests_run} = '0;
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{rx_above_pos, rx_above_neg} = 2'b00;
		hsize = 3'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(32'h6c, 1'b1, 32'h7);
		rd(32'h6c, 32'h0);
		rd(32'h68, 32'h0);
		do @(negedge hclk); while (tp_tx_oe !== 1'b1);
		n = 0;
		do begin @(negedge hclk); n++; end while (tp_tx_oe !== 1'b1);
		check("link pulse period", 200, n);
		wr(32'h2);
		rd(32'h68, 32'h402);
		fork mac.send(4, 4'h5); join_none
		do @(negedge hclk); while (tp_tx_oe !== 1'b1);
		repeat (8) begin bits = {bits[6:0], tp_tx_out}; @(negedge hclk); end
		check("encoded nibble", 32'h66, bits);
		wait fork;
		count_col(n);
		check("heartbeat cycles", 10, n);
		for (int m = 0; m < 2; m++) begin
			wr(m ? 32'h6 : 32'h3);
			mac.send(4, 4'h1);
			count_col(n);
			check("muted heartbeat", 0, n);
		end
		// Receive during transmit: full duplex, then half duplex
		for (int m = 0; m < 2; m++) begin
			wr(m ? 32'h2 : 32'h6);
			fork mac.send(4, 4'h3); join_none
			burst(24, 1'b0);
			@(negedge hclk);
			check("carrier", 1, crs);
			check("lowered squelch", 1, squelch_reduced);
			check("data valid", 1, rx_dv);
			check("collision", m, col);
			wait fork;
			repeat (60) @(posedge hclk);
		end
		// Incomplete crossings are noise; a full burst ends after a gap
		burst(2, 1'b0);
		repeat (6) @(negedge hclk);
		check("noise carrier", 0, crs);
		burst(12, 1'b0);
		repeat (7) @(negedge hclk);
		check("end of packet carrier", 0, crs);
		// Receive clock keeps running a few cycles after carrier, then stops
		n = 0;
		repeat (20) @(negedge hclk) if (rx_clk === 1'b1) n++;
		check("receive clock tail", 1, (n >= 4) && (rx_clk === 1'b0));
		repeat (3) begin burst(1, 1'b1); repeat (30) @(posedge hclk); end
		rd(32'h68, 32'h502);
		wr(32'h102);
		rd(32'h68, 32'h402);
		mac.send(50, 4'h0);
		rd(32'h68, 32'h602);
		check("jabber collision", 1, col);
		repeat (450) @(posedge hclk);
		rd(32'h68, 32'h402);
		results();
	end
endmodule
`default_nettype wire
